// [profile_select_gain_writer_test.sv]
// Self-checking testbench for the profile store and gain writer
`timescale 1ns/1ps
module profile_select_gain_writer_test
  import psg_pkg::*;
;
  logic sys_clk, rst_n, ps_hi, ps_lo, wr, av, byp, div, pwr, a_clk, a_dat, a_en, busy;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, act_gain, m_gain;
  logic [1:0] p_idx;
  psg_profile_s act;
  int frames, aborts, en_len, n_fail = 0, n_tests = 0, nf, na;
  logic [4:0] gaddr [4] = '{PSG_ADDR_GAIN_P1, PSG_ADDR_GAIN_P2, PSG_ADDR_GAIN_P3, PSG_ADDR_GAIN_P4};
  logic [7:0] gval [4] = '{8'ha5, 8'h3c, 8'hff, 8'h5a};
  ////////////////////////////////////////////////////////////////////////////
  psg_gain_writer i_psg_gain_writer (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .profile_select_high_i(ps_hi), .profile_select_low_i(ps_lo), .reg_wr_i(wr),
    .reg_addr_valid_i(av), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reference_clock_input_mult_bypass_i(byp), .reg_rdata_o(rdata), .active_profile_o(act),
    .profile_index_o(p_idx), .active_gain_o(act_gain), .core_clock_divide_o(div),
    .reference_clock_input_mult_power_o(pwr), .amp_serial_clock_o(a_clk), .amp_serial_data_o(a_dat),
    .amp_serial_enable_o(a_en), .xfer_busy_o(busy));
  psg_amp_model i_psg_amp_model (.sys_clk_i(sys_clk), .amp_serial_clock_i(a_clk),
    .amp_serial_data_i(a_dat), .amp_serial_enable_i(a_en), .gain_o(m_gain),
    .frames_o(frames), .aborts_o(aborts), .enable_len_o(en_len));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cnt(input string what, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    wdata = d;
    av = 1'b1;
    wr = 1'b1;
    @(negedge sys_clk);
    av = 1'b0;
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    addr = a;
    av = 1'b1;
    @(negedge sys_clk);
    av = 1'b0;
    chk_val("reg_rdata", {24'h0, exp}, {24'h0, rdata});
  endtask
  task automatic wait_xfer();
    int k, j;
    repeat (3) @(negedge sys_clk);
    for (k = 0; k < 10 && busy !== 1'b1; k++) @(negedge sys_clk);
    for (j = 0; j < 300 && busy !== 1'b0; j++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    if (k >= 10 || j >= 300) begin
      n_fail++;
      $display("MISMATCH xfer_busy expected end seen timeout");
      give_verdict();
    end
  endtask
  task automatic chk_frame(input logic [7:0] g);
    chk_cnt("frames", nf + 1, frames);
    chk_val("amp_gain", {24'h0, g}, {24'h0, m_gain});
    nf = frames;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, ps_hi, ps_lo, wr, av, byp, addr, wdata} = '0;
    nf = 0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk_val("mult_power", 1, pwr);
    wait_xfer();
    chk_frame(PSG_GAIN_RESET);
    chk_cnt("enable_len", PSG_XFER_CYCLES - 1, en_len);
    for (int p = 0; p < 4; p++) rd_chk(gaddr[p], 8'h00);
    for (int p = 0; p < 4; p++) wr_reg(gaddr[p], gval[p]);
    wait_xfer();
    chk_frame(gval[0]);
    for (int p = 0; p < 4; p++) rd_chk(gaddr[p], gval[p]);
    for (int i = 1; i <= 4; i++) begin
      {ps_hi, ps_lo} = 2'(i % 4);
      wait_xfer();
      chk_frame(gval[i % 4]);
      chk_val("profile_index", i % 4, p_idx);
      chk_val("active_gain", gval[i % 4], act_gain);
    end
    na = aborts;
    wr_reg(gaddr[2], 8'h77);
    repeat (40) @(negedge sys_clk);
    wr_reg(gaddr[0], 8'hc3);
    wait_xfer();
    chk_frame(8'hc3);
    chk_cnt("aborts", na + 1, aborts);
    {ps_hi, ps_lo} = 2'b10;
    repeat (40) @(negedge sys_clk);
    na = aborts;
    rd_chk(gaddr[3], gval[3]);
    wait_xfer();
    chk_frame(8'h77);
    chk_cnt("aborts", na + 1, aborts);
    for (int b = 0; b < 4; b++) wr_reg(5'(14 + b), 8'(8'h78 - b * 8'h22));
    wr_reg(5'(14 + PSG_OFS_INTERP), 8'hfe);
    repeat (2) @(negedge sys_clk);
    chk_val("ftw", 32'h1234_5678, act.freq_tuning_word);
    chk_val("interp", {24'h0, 6'h3f, 2'b10}, {24'h0, act.interp_rate, act.spectral_invert,
      act.hb3_bypass});
    chk_val("busy", 0, busy);
    wr_reg(5'(14 + PSG_OFS_INTERP), 8'h09);
    repeat (2) @(negedge sys_clk);
    chk_val("interp", {24'h0, 6'h02, 2'b01}, {24'h0, act.interp_rate, act.spectral_invert,
      act.hb3_bypass});
    rd_chk(5'(14 + PSG_OFS_INTERP), 8'h09);
    rd_chk(5'(14 + 3), 8'h12);
    rd_chk(5'h1f, 8'h00);
    byp = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_val("clock_divide", 1, div);
    chk_val("mult_power", 1, pwr);
    byp = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_val("clock_divide", 0, div);
    give_verdict();
  end
endmodule

// [psg_amp_model.sv]
// Behavioural model of the external gain amplifier serial input port
`timescale 1ns/1ps
module psg_amp_model (
  input wire logic sys_clk_i,
  input wire logic amp_serial_clock_i,
  input wire logic amp_serial_data_i,
  input wire logic amp_serial_enable_i,
  output logic [7:0] gain_o,
  output int frames_o,
  output int aborts_o,
  output int enable_len_o
);
  logic [7:0] shift = 8'h00;
  int bits = 0;
  int len = 0;
  logic clk_q = 1'b0;
  logic en_q = 1'b0;
  // Start away from zero so the power-up word is seen to land
  initial begin
    gain_o = 8'hff;
    frames_o = 0;
    aborts_o = 0;
    enable_len_o = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    clk_q <= amp_serial_clock_i;
    en_q <= amp_serial_enable_i;
    if (amp_serial_enable_i === 1'b1) begin
      len <= len + 1;
      if (amp_serial_clock_i === 1'b1 && clk_q === 1'b0) begin
        shift <= {shift[6:0], amp_serial_data_i};
        bits <= bits + 1;
      end
    end else if (en_q === 1'b1) begin
      enable_len_o <= len;
      len <= 0;
      bits <= 0;
      // Only a whole byte is latched on the enable fall
      if (bits == 8) begin
        gain_o <= shift;
        frames_o <= frames_o + 1;
      end else begin
        aborts_o <= aborts_o + 1;
      end
    end
  end
endmodule

// [psg_gain_writer.sv]
// Profile register store, profile select and amplifier gain serial writer
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: Four 8-bit gain registers, one for each profile.
// R2: A gain transfer uses three output pins and lasts 136 clock cycles.
// R3: Reset clears the gain registers, then sends a zero gain word.
// R4: A changed profile selection starts a transfer of that profile's gain.
// R5: Writing any gain register starts a transfer of the current profile's gain.
// R6: Addressing a gain register mid-transfer abandons it and restarts fresh.
// R7: Tuning word is four bytes, lowest address least significant.
// R8: Output frequency is tuning word times clock over two to the 32.
// R9: Interpolation rate is six bits, 2 to 63, in the top bits. The code does not block rates 0 and 1, and reset loads 0.
// R10: Bit 1 of interpolation byte selects spectral inversion.
// R11: Bit 0 of interpolation byte bypasses third half-band filter.
// R12: The gain word goes to the amplifier unchanged.
// R13: Select pins as binary, high pin MSB, choose profiles 1 to 4.
// R14: Host should drop the transmit gate around profile changes.
// R15: Host should not change interpolation rate during a burst.
// R16: Multiplier bypass divides internal clocks but keeps the multiplier locked.
// R17: Registers reached by host serial port with 5-bit addresses.
// R18: Select pins are registered and compared to detect a change.
// R19: Enable asserts, eight bits clocked out, enable drops to latch.
module psg_gain_writer
  import psg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic profile_select_high_i,
  input wire logic profile_select_low_i,
  input wire logic reg_wr_i,
  input wire logic reg_addr_valid_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reference_clock_input_mult_bypass_i,
  output logic [7:0] reg_rdata_o,
  output psg_profile_s active_profile_o,
  output logic [1:0] profile_index_o,
  output logic [7:0] active_gain_o,
  output logic core_clock_divide_o,
  output logic reference_clock_input_mult_power_o,
  output logic amp_serial_clock_o,
  output logic amp_serial_data_o,
  output logic amp_serial_enable_o,
  output logic xfer_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  function automatic logic is_gain_addr(input logic [4:0] a);
    is_gain_addr = (a == PSG_ADDR_GAIN_P1) || (a == PSG_ADDR_GAIN_P2) ||
                   (a == PSG_ADDR_GAIN_P3) || (a == PSG_ADDR_GAIN_P4);
  endfunction

  function automatic logic [4:0] prof_base(input int unsigned p);
    prof_base = 5'(PSG_ADDR_FTW_P1 + 5'(p) * PSG_PROFILE_STRIDE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Profile register store

  logic [7:0] gain_word [PSG_NUM_PROFILES];
  logic [31:0] tuning_word_bytes [PSG_NUM_PROFILES];
  logic [7:0] interp_byte [PSG_NUM_PROFILES];
  logic [7:0] rd_mux [PSG_NUM_PROFILES];

  genvar gp;
  generate
    for (gp = 0; gp < PSG_NUM_PROFILES; gp++) begin : g_prof
      localparam logic [4:0] BASE = prof_base(gp);
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          gain_word[gp] <= PSG_GAIN_RESET; // R1 R3
          tuning_word_bytes[gp] <= PSG_FTW_RESET;
          interp_byte[gp] <= PSG_INTERP_RESET;
        end else if (reg_wr_i) begin
          if (reg_addr_i == 5'(BASE + PSG_OFS_INTERP + 5'h01)) begin
            gain_word[gp] <= reg_wdata_i; // R1
          end
          if (reg_addr_i == 5'(BASE + PSG_OFS_INTERP)) begin
            interp_byte[gp] <= reg_wdata_i;
          end
          for (int b = 0; b < 4; b++) begin
            if (reg_addr_i == 5'(BASE + 5'(b))) begin
              tuning_word_bytes[gp][8*b +: 8] <= reg_wdata_i; // R7
            end
          end
        end
      end
      always_comb begin
        rd_mux[gp] = 8'h00;
        if (reg_addr_i == 5'(BASE + PSG_OFS_INTERP + 5'h01)) begin
          rd_mux[gp] = gain_word[gp];
        end else if (reg_addr_i == 5'(BASE + PSG_OFS_INTERP)) begin
          rd_mux[gp] = interp_byte[gp];
        end else begin
          for (int b = 0; b < 4; b++) begin
            if (reg_addr_i == 5'(BASE + 5'(b))) begin
              rd_mux[gp] = tuning_word_bytes[gp][8*b +: 8];
            end
          end
        end
      end
    end
  endgenerate

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    for (int p = 0; p < PSG_NUM_PROFILES; p++) begin
      next_rdata = next_rdata | rd_mux[p];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Profile selection

  logic [1:0] sel_q;
  logic sel_seen;
  wire logic [1:0] sel_now = {profile_select_high_i, profile_select_low_i}; // R13
  wire logic sel_change = sel_seen && (sel_now != sel_q); // R18

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sel_q <= 2'b00;
      sel_seen <= 1'b0;
    end else begin
      sel_q <= sel_now; // R18
      sel_seen <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      active_profile_o <= '0;
      profile_index_o <= 2'b00;
      active_gain_o <= PSG_GAIN_RESET;
    end else begin
      profile_index_o <= sel_now; // R13
      active_profile_o.freq_tuning_word <= tuning_word_bytes[sel_now]; // R7 R8
      active_profile_o.interp_rate <= interp_byte[sel_now][7:PSG_INTERP_SHIFT]; // R9
      active_profile_o.spectral_invert <= interp_byte[sel_now][PSG_INV_BIT]; // R10
      active_profile_o.hb3_bypass <= interp_byte[sel_now][PSG_HB3_BYPASS_BIT]; // R11
      active_gain_o <= gain_word[sel_now];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference multiplier bypass

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      core_clock_divide_o <= 1'b0;
      reference_clock_input_mult_power_o <= 1'b1;
    end else begin
      core_clock_divide_o <= reference_clock_input_mult_bypass_i; // R16
      reference_clock_input_mult_power_o <= 1'b1; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain transfer engine

  psg_state_e state;
  logic [7:0] cyc;
  logic [7:0] shreg;
  logic pending_start;
  logic power_up_pending;
  wire logic gain_touch = reg_addr_valid_i && is_gain_addr(reg_addr_i); // R6
  wire logic gain_write = reg_wr_i && is_gain_addr(reg_addr_i); // R5

  wire logic start_now = pending_start || power_up_pending;
  // Only an idle engine with the gain addresses left alone may launch
  wire logic launch = (state == PSG_ST_IDLE) && start_now && !gain_touch;

  // Starts stay pending until launched, so a held address cannot lose them
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pending_start <= 1'b0;
      power_up_pending <= 1'b1; // R3
    end else begin
      pending_start <= gain_write || sel_change || (gain_touch && state == PSG_ST_SEND) ||
                       (pending_start && !launch); // R4 R5 R6
      power_up_pending <= power_up_pending && !launch; // R3
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= PSG_ST_IDLE;
      cyc <= 8'h00;
      shreg <= 8'h00;
    end else begin
      case (state)
        PSG_ST_IDLE: begin
          if (launch) begin
            state <= PSG_ST_SEND;
            cyc <= 8'h00;
            shreg <= gain_word[sel_q]; // R4 R12
          end
        end
        PSG_ST_SEND: begin
          if (gain_touch || start_now) begin
            // Back to idle so the amplifier sees enable fall before a fresh word
            state <= PSG_ST_IDLE; // R4 R6
            cyc <= 8'h00;
          end else if (cyc == PSG_XFER_LAST) begin
            state <= PSG_ST_IDLE; // R2
            cyc <= 8'h00;
          end else begin
            cyc <= cyc + 8'h01;
            if (cyc >= PSG_SHIFT_START && cyc < PSG_SHIFT_END &&
                cyc[3:0] == PSG_CLK_FALL - 4'h1) begin
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
        default: begin
          state <= PSG_ST_IDLE;
          cyc <= 8'h00;
        end
      endcase
    end
  end

  psg_amp_s next_amp;
  logic in_shift;
  always_comb begin
    next_amp = '0;
    in_shift = (cyc >= PSG_SHIFT_START) && (cyc < PSG_SHIFT_END);
    if (state == PSG_ST_SEND && !gain_touch && !start_now && cyc != PSG_XFER_LAST) begin
      next_amp.amp_serial_enable = 1'b1; // R19
      next_amp.amp_serial_data = shreg[7]; // R12
      next_amp.amp_serial_clock = in_shift && (cyc[3:0] >= PSG_CLK_RISE) &&
                                  (cyc[3:0] < PSG_CLK_FALL);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      amp_serial_clock_o <= 1'b0;
      amp_serial_data_o <= 1'b0;
      amp_serial_enable_o <= 1'b0;
      xfer_busy_o <= 1'b0;
    end else begin
      amp_serial_clock_o <= next_amp.amp_serial_clock; // R2 R19
      amp_serial_data_o <= next_amp.amp_serial_data;
      amp_serial_enable_o <= next_amp.amp_serial_enable;
      xfer_busy_o <= (state == PSG_ST_SEND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] en_run;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      en_run <= 8'h00;
    end else if (amp_serial_enable_o) begin
      en_run <= en_run + 8'h01;
    end else begin
      en_run <= 8'h00;
    end
  end

  a_xfer_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
    en_run <= 8'(PSG_XFER_LAST))
    else $error("transfer longer than allowed");

  a_gain_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R3
    $rose(rst_n_i) |-> gain_word[0] == 8'h00 && gain_word[1] == 8'h00 &&
                       gain_word[2] == 8'h00 && gain_word[3] == 8'h00)
    else $error("gain not cleared");

  sequence s_sel_seen;
    sel_change && !gain_touch;
  endsequence

  sequence s_quiet_two;
    (!gain_touch && !sel_change && !gain_write) [*2];
  endsequence

  a_sel_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R4
    s_sel_seen ##1 s_quiet_two |=> state == PSG_ST_SEND && cyc <= 8'h01)
    else $error("profile change did not start transfer");

  a_write_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R5
    gain_write |=> ##[1:2] amp_serial_enable_o || gain_touch || $past(gain_touch))
    else $error("gain write did not start transfer");

  a_abort_now: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R6
    gain_touch |=> !amp_serial_enable_o)
    else $error("transfer not abandoned");

  a_sel_track: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
    1'b1 |=> profile_index_o == $past(sel_now))
    else $error("profile index wrong");

  a_clk_inside: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R19
    amp_serial_clock_o |-> amp_serial_enable_o)
    else $error("clock outside enable");

  a_bypass_div: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R16
    reference_clock_input_mult_bypass_i |=> core_clock_divide_o && reference_clock_input_mult_power_o)
    else $error("bypass handling wrong");

  a_power_up: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R3
    $rose(rst_n_i) && !gain_touch |=> state == PSG_ST_SEND && shreg == PSG_GAIN_RESET)
    else $error("power-up transfer not started");

  a_launch_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
    launch |=> ##1 xfer_busy_o)
    else $error("launch did not raise busy");

  a_abort_arm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R6
    gain_touch && state == PSG_ST_SEND |=> pending_start && state == PSG_ST_IDLE)
    else $error("abort did not arm a restart");

  a_data_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R19
    amp_serial_clock_o && $past(amp_serial_clock_o) |-> $stable(amp_serial_data_o))
    else $error("data moved while clock high");

  a_clk_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
    $fell(amp_serial_clock_o) |-> !amp_serial_clock_o [*4])
    else $error("clock low phase too short");

  a_rdata_gain: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R17
    reg_addr_i == PSG_ADDR_GAIN_P1 |=> reg_rdata_o == $past(gain_word[0]))
    else $error("gain read data wrong");

endmodule

// [psg_pkg.sv]
// Constants and types for the profile store and amplifier gain writer
package psg_pkg;
  localparam int unsigned PSG_NUM_PROFILES = 4;
  localparam logic [4:0] PSG_ADDR_GAIN_P1 = 5'h07;
  localparam logic [4:0] PSG_ADDR_GAIN_P2 = 5'h0d;
  localparam logic [4:0] PSG_ADDR_GAIN_P3 = 5'h13;
  localparam logic [4:0] PSG_ADDR_GAIN_P4 = 5'h19;
  // Profile base: tuning bytes at base..base+3, interp byte at base+4, gain at base+5
  localparam logic [4:0] PSG_ADDR_FTW_P1 = 5'h02;
  localparam logic [4:0] PSG_PROFILE_STRIDE = 5'h06;
  localparam logic [4:0] PSG_OFS_INTERP = 5'h04;
  localparam logic [7:0] PSG_GAIN_RESET = 8'h00;
  localparam logic [7:0] PSG_INTERP_RESET = 8'h00;
  localparam logic [31:0] PSG_FTW_RESET = 32'h0000_0000;
  localparam int unsigned PSG_INTERP_SHIFT = 2;
  localparam int unsigned PSG_INV_BIT = 1;
  localparam int unsigned PSG_HB3_BYPASS_BIT = 0;
  localparam logic [5:0] PSG_INTERP_MIN = 6'h02;
  // Transfer length in core clock cycles
  localparam int unsigned PSG_XFER_CYCLES = 136;
  localparam logic [7:0] PSG_XFER_LAST = 8'(PSG_XFER_CYCLES - 1);
  // Each gain bit occupies 16 cycles: data set at 12 as clock falls (first bit at 0), clock high 4..11
  localparam int unsigned PSG_BIT_CYCLES = 16;
  localparam logic [7:0] PSG_SHIFT_START = 8'h04;
  localparam logic [3:0] PSG_CLK_RISE = 4'h4;
  localparam logic [3:0] PSG_CLK_FALL = 4'hc;
  localparam logic [7:0] PSG_SHIFT_END = 8'(PSG_SHIFT_START + 8 * PSG_BIT_CYCLES);

  typedef enum logic [1:0] {
    PSG_ST_IDLE = 2'b01,
    PSG_ST_SEND = 2'b10
  } psg_state_e;

  typedef struct packed {
    logic [31:0] freq_tuning_word;
    logic [5:0] interp_rate;
    logic spectral_invert;
    logic hb3_bypass;
  } psg_profile_s;

  typedef struct packed {
    logic amp_serial_clock;
    logic amp_serial_data;
    logic amp_serial_enable;
  } psg_amp_s;
endpackage
